/* logic/mitc_top.sv */
// Interrupt flags and enables, request pin, temperature control, converter filters
`timescale 1ns/1ps
module mitc_top (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic sclk,
   input wire logic csN,
   input wire logic din,
   output logic dout,
   output logic doutOeN,
   input wire logic [mitc_pkg::DATA_W-1:0] eventIn,
   input wire logic zeroCross,
   input wire logic [mitc_pkg::CHANNELS-1:0] modBit,
   output logic irqN,
   output logic sensorRoute,
   output logic modClk,
   output logic [mitc_pkg::WORD_W-1:0] ch1Word,
   output logic [mitc_pkg::WORD_W-1:0] ch2Word
);
   import mitc_pkg::*;

   logic [DATA_W-1:0] flags;
   logic [DATA_W-1:0] enables;
   logic [DATA_W-1:0] mode;
   logic [TEMP_W-1:0] temperature;
   logic [DATA_W-1:0] pubFlags;
   logic [DATA_W-1:0] pubEnables;
   logic [DATA_W-1:0] pubMode;
   logic [TEMP_W-1:0] pubTemp;
   logic [ADDR_W-1:0] linkAddr;
   logic [DATA_W-1:0] linkData;
   logic linkClr;
   logic linkHold;
   logic linkWr;
   logic [SYNC_W-1:0] rawLevel;
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic [SYNC_W-1:0] sync3;
   logic [SYNC_W-1:0] level;
   logic [SYNC_W-1:0] levelPrev;
   logic [SYNC_W-1:0] next_level;
   logic [SYNC_W-1:0] rise;
   logic pubOk;
   logic [DATA_W-1:0] clearMask;
   logic [DATA_W-1:0] allEvents;
   logic [DIV_W-1:0] divCnt;
   logic quarterTick;
   mitc_temp_state_type tempState;
   logic [TEMP_CNT_W-1:0] tickCnt;
   logic convDone;
   logic tempDone;
   logic [WORD_W-1:0] chWord [CHANNELS];

   function automatic logic [WORD_W-1:0] filterWord(input logic [FILT_CNT_W-1:0] ones);
      logic signed [FILT_DIFF_W-1:0] diff;
      diff = FILT_DIFF_W'({ones, 1'b0}) - FILT_DIFF_W'(FILT_SAMPLES);
      filterWord = {diff, {FILT_PAD{1'b0}}};
   endfunction : filterWord

   mitc_link link (
      .sclk(sclk),
      .csN(csN),
      .din(din),
      .pubFlags(pubFlags),
      .pubEnables(pubEnables),
      .pubMode(pubMode),
      .pubTemp(pubTemp),
      .wrAddr(linkAddr),
      .wrData(linkData),
      .clrLevel(linkClr),
      .holdLevel(linkHold),
      .wrLevel(linkWr),
      .dout(dout),
      .doutOeN(doutOeN)
   );

   // Serial side levels cross through three flops
   assign rawLevel = {linkWr, linkHold, linkClr, ~csN};

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= rawLevel;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // A level changes only once the last two stages agree
   assign next_level = (sync2 & sync3) | (level & (sync2 | sync3));
   assign rise = level & ~levelPrev;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         level <= '0;
         levelPrev <= '0;
      end else begin
         level <= next_level;
         levelPrev <= level;
      end
   end

   // Snapshot only while the link is quiet, so the serial side reads stable words
   assign pubOk = ~(|(level | sync2 | sync3));

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pubFlags <= FLAGS_RESET;
         pubEnables <= ENABLES_RESET;
         pubMode <= MODE_RESET;
         pubTemp <= TEMP_RESET;
      end else if (pubOk) begin
         pubFlags <= flags;
         pubEnables <= enables;
         pubMode <= mode;
         pubTemp <= temperature;
      end
   end

   // Only the flags the host was shown are cleared
   assign clearMask = rise[LVL_CLEAR] ? pubFlags : '0;
   assign allEvents = eventIn | (tempDone ? TEMP_FLAG_MASK : '0);

   // New events win over the clear in the same cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         flags <= FLAGS_RESET;
      end else begin
         flags <= (flags & ~clearMask) | allEvents;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         enables <= ENABLES_RESET;
      end else if (rise[LVL_WRITE] && linkAddr == ADDR_ENABLES) begin
         enables <= linkData;
      end
   end

   // Start bit clears itself when the result lands; a host write takes priority
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mode <= MODE_RESET;
      end else if (rise[LVL_WRITE] && linkAddr == ADDR_MODE) begin
         mode <= linkData;
      end else if (convDone) begin
         mode[MODE_TEMP_START_BIT] <= 1'b0;
      end
   end

   // Request pin held high across the status read, then reflects pending state
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irqN <= 1'b1;
      end else if (level[LVL_HOLD]) begin
         irqN <= 1'b1;
      end else begin
         irqN <= ~(|(flags & enables));
      end
   end

   // Quarter-rate modulator clock
   assign quarterTick = (divCnt == DIV_W'(QUARTER_DIV - 1));

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         divCnt <= '0;
         modClk <= 1'b0;
      end else begin
         divCnt <= divCnt + DIV_W'(1);
         modClk <= (divCnt >= DIV_W'(QUARTER_HALF - 1)) && !quarterTick;
      end
   end

   // Temperature conversion sequencing
   assign convDone = (tempState == T_CONV) && quarterTick
      && (tickCnt == TEMP_CNT_W'(TEMP_PERIODS - 1));

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tempState <= T_IDLE;
         tickCnt <= '0;
         sensorRoute <= 1'b0;
         tempDone <= 1'b0;
         temperature <= TEMP_RESET;
      end else begin
         tempDone <= 1'b0;
         case (tempState)
            T_IDLE: begin
               if (mode[MODE_TEMP_START_BIT]) begin
                  tempState <= T_WAIT;
               end
            end
            T_WAIT: begin
               if (!mode[MODE_TEMP_START_BIT]) begin
                  tempState <= T_IDLE;
               end else if (zeroCross) begin
                  tempState <= T_CONV;
                  sensorRoute <= 1'b1;
                  tickCnt <= '0;
               end
            end
            T_CONV: begin
               if (convDone) begin
                  // Top byte of the signed channel-one word keeps the two's complement sign
                  temperature <= chWord[0][WORD_W-1 -: TEMP_W];
                  tempDone <= 1'b1;
                  sensorRoute <= 1'b0;
                  tempState <= T_IDLE;
               end else if (quarterTick) begin
                  tickCnt <= tickCnt + TEMP_CNT_W'(1);
               end
            end
            default: begin
               tempState <= T_IDLE;
            end
         endcase
      end
   end

   // Boxcar average per channel; a short window trades resolution for latency
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : gFilter
         logic [FILT_CNT_W-1:0] ones;
         logic [FILT_CNT_W-1:0] samples;
         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               ones <= '0;
               samples <= '0;
               chWord[ch] <= '0;
            end else if (quarterTick) begin
               if (samples == FILT_CNT_W'(FILT_SAMPLES - 1)) begin
                  chWord[ch] <= filterWord(ones + FILT_CNT_W'(modBit[ch]));
                  ones <= '0;
                  samples <= '0;
               end else begin
                  ones <= ones + FILT_CNT_W'(modBit[ch]);
                  samples <= samples + FILT_CNT_W'(1);
               end
            end
         end
      end
   endgenerate

   assign ch1Word = chWord[0];
   assign ch2Word = chWord[1];

endmodule : mitc_top

/* logic/mitc_pkg.sv */
// Shared constants and types for the interrupt and temperature block
package mitc_pkg;

   // Serial frame layout
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned TEMP_W = 8;
   localparam int unsigned CMD_BITS = 8;
   localparam int unsigned FRAME_BITS = 24;
   localparam int unsigned WRITE_BIT = 7;
   localparam int unsigned CNT_W = 5;
   localparam int unsigned IDX_W = 4;

   // Register addresses
   localparam logic [5:0] ADDR_MODE = 6'h09;
   localparam logic [5:0] ADDR_ENABLES = 6'h0A;
   localparam logic [5:0] ADDR_FLAGS = 6'h0B;
   localparam logic [5:0] ADDR_STATUS_CLR = 6'h0C;
   localparam logic [5:0] ADDR_TEMP = 6'h10;

   // Reset values
   localparam logic [15:0] FLAGS_RESET = 16'h0000;
   localparam logic [15:0] ENABLES_RESET = 16'h0000;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [7:0] TEMP_RESET = 8'h00;

   // Field positions
   localparam int unsigned MODE_TEMP_START_BIT = 5;
   localparam logic [15:0] TEMP_FLAG_MASK = 16'h0020;

   // Converter timing
   localparam int unsigned QUARTER_DIV = 4;
   localparam int unsigned QUARTER_HALF = QUARTER_DIV / 2;
   localparam int unsigned DIV_W = 2;
   localparam int unsigned TEMP_PERIODS = 24;
   localparam int unsigned TEMP_CNT_W = 5;
   localparam int unsigned CHANNELS = 2;
   localparam int unsigned FILT_SAMPLES = 32;
   localparam int unsigned FILT_CNT_W = 6;
   localparam int unsigned WORD_W = 24;
   localparam int unsigned FILT_DIFF_W = FILT_CNT_W + 1;
   localparam int unsigned FILT_PAD = WORD_W - FILT_DIFF_W;

   // Crossing levels from the serial side
   localparam int unsigned SYNC_W = 4;
   localparam int unsigned LVL_FRAME = 0;
   localparam int unsigned LVL_CLEAR = 1;
   localparam int unsigned LVL_HOLD = 2;
   localparam int unsigned LVL_WRITE = 3;

   typedef enum logic [2:0] {
      T_IDLE = 3'h1,
      T_WAIT = 3'h2,
      T_CONV = 3'h4
   } mitc_temp_state_type;

endpackage : mitc_pkg

/* logic/mitc_link.sv */
// Serial port end of the block, clocked by the serial clock
`timescale 1ns/1ps
module mitc_link (
   input wire logic sclk,
   input wire logic csN,
   input wire logic din,
   input wire logic [mitc_pkg::DATA_W-1:0] pubFlags,
   input wire logic [mitc_pkg::DATA_W-1:0] pubEnables,
   input wire logic [mitc_pkg::DATA_W-1:0] pubMode,
   input wire logic [mitc_pkg::TEMP_W-1:0] pubTemp,
   output logic [mitc_pkg::ADDR_W-1:0] wrAddr,
   output logic [mitc_pkg::DATA_W-1:0] wrData,
   output logic clrLevel,
   output logic holdLevel,
   output logic wrLevel,
   output logic dout,
   output logic doutOeN
);
   import mitc_pkg::*;

   logic [CNT_W-1:0] bitCount;
   logic [DATA_W-2:0] shiftIn;
   logic [CMD_BITS-1:0] command;
   logic [CMD_BITS-1:0] cmdNow;
   logic [DATA_W-1:0] readWord;
   logic [IDX_W-1:0] outIdx;
   logic inData;
   logic isRead;

   assign cmdNow = {shiftIn[CMD_BITS-2:0], din};
   assign wrAddr = command[ADDR_W-1:0];
   assign isRead = ~command[WRITE_BIT];
   assign inData = (bitCount >= CNT_W'(CMD_BITS)) && (bitCount < CNT_W'(FRAME_BITS));
   assign outIdx = IDX_W'(CNT_W'(FRAME_BITS - 1) - bitCount);

   // Published words hold still while the frame is open
   always_comb begin
      readWord = '0;
      if (wrAddr == ADDR_STATUS_CLR) begin
         readWord = pubFlags;
      end else if (wrAddr == ADDR_FLAGS) begin
         readWord = pubFlags;
      end else if (wrAddr == ADDR_ENABLES) begin
         readWord = pubEnables;
      end else if (wrAddr == ADDR_MODE) begin
         readWord = pubMode;
      end else if (wrAddr == ADDR_TEMP) begin
         readWord = {{(DATA_W - TEMP_W){1'b0}}, pubTemp};
      end
   end

   // Frame state ends with the select line, as the clock stops between frames
   always_ff @(negedge sclk or posedge csN) begin
      if (csN) begin
         bitCount <= '0;
         clrLevel <= 1'b0;
         holdLevel <= 1'b0;
         wrLevel <= 1'b0;
      end else begin
         if (bitCount != CNT_W'(FRAME_BITS)) begin
            bitCount <= bitCount + CNT_W'(1);
         end
         if (bitCount == CNT_W'(CMD_BITS - 1) && !cmdNow[WRITE_BIT]
             && cmdNow[ADDR_W-1:0] == ADDR_STATUS_CLR) begin
            clrLevel <= 1'b1;
            holdLevel <= 1'b1;
         end
         if (bitCount == CNT_W'(FRAME_BITS - 1)) begin
            holdLevel <= 1'b0;
            wrLevel <= command[WRITE_BIT];
         end
      end
   end

   // Data path needs no reset
   always_ff @(negedge sclk) begin
      shiftIn <= {shiftIn[DATA_W-3:0], din};
      if (!csN && bitCount == CNT_W'(CMD_BITS - 1)) begin
         command <= cmdNow;
      end
      if (!csN && bitCount == CNT_W'(FRAME_BITS - 1)) begin
         wrData <= {shiftIn, din};
      end
   end

   // Data out changes on the rising edge, host samples on the falling edge
   always_ff @(posedge sclk or posedge csN) begin
      if (csN) begin
         dout <= 1'b0;
         doutOeN <= 1'b1;
      end else if (isRead && inData) begin
         dout <= readWord[outIdx];
         doutOeN <= 1'b0;
      end else begin
         doutOeN <= 1'b1;
      end
   end

endmodule : mitc_link

/* verification/mitc_top_asserts.sv */
// Port checker for the interrupt and temperature block
`timescale 1ns/1ps
module mitc_top_asserts (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic csN,
   input wire logic dout,
   input wire logic doutOeN,
   input wire logic zeroCross,
   input wire logic irqN,
   input wire logic sensorRoute,
   input wire logic modClk,
   input wire logic [mitc_pkg::WORD_W-1:0] ch1Word,
   input wire logic [mitc_pkg::WORD_W-1:0] ch2Word
);
   import mitc_pkg::*;
   logic [7:0] routeCnt;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Counts routed cycles; too long for a repetition
   always_ff @(posedge mclk) begin
      if (sys_rst || !sensorRoute) routeCnt <= 8'h00;
      else routeCnt <= routeCnt + 8'h01;
   end
   sequence quarterCycle;
      modClk [*2] ##1 !modClk [*2] ##1 modClk;
   endsequence
   chk_reset_quiet: assert property (disable iff (1'b0)
      sys_rst |=> irqN && !sensorRoute && !modClk) else $error("not quiet after reset");
   chk_modclk_rate: assert property ($rose(modClk) |-> quarterCycle)
      else $error("modulator clock not a quarter rate");
   chk_word_grid: assert property (ch1Word[16:0] == 17'h0 && ch2Word[16:0] == 17'h0)
      else $error("filter word off its grid");
   chk_word_hold: assert property ($changed(ch1Word) |=> $stable(ch1Word) [*8])
      else $error("filter word changes too often");
   chk_route_start: assert property ($rose(sensorRoute) |->
      $past(zeroCross) || $past(zeroCross, 2)) else $error("route without zero crossing");
   chk_route_done: assert property ($fell(sensorRoute) |-> routeCnt inside {[92:97]})
      else $error("conversion length wrong");
   chk_route_bound: assert property (routeCnt <= 8'd97)
      else $error("conversion overran");
   chk_irq_rise_frame: assert property ($rose(irqN) |-> !csN)
      else $error("request released outside a frame");
   chk_irq_hold: assert property ($rose(irqN) |=> irqN [*2])
      else $error("request not held during status data");
   chk_link_idle: assert property (csN |-> doutOeN && !dout)
      else $error("data out driven while deselected");
endmodule : mitc_top_asserts
bind mitc_top mitc_top_asserts i_mitc_top_asserts (.mclk(mclk), .sys_rst(sys_rst),
   .csN(csN), .dout(dout), .doutOeN(doutOeN), .zeroCross(zeroCross), .irqN(irqN),
   .sensorRoute(sensorRoute), .modClk(modClk), .ch1Word(ch1Word), .ch2Word(ch2Word));

/* verification/mitc_host.sv */
// Host model: serial master with an edge-triggered request input
`timescale 1ns/1ps
module mitc_host (
   output logic sclk,
   output logic csN,
   output logic din,
   input wire logic dout,
   input wire logic irqN
);
   logic irqFlag;
   // Select rises just after time zero so the link side sees its reset edge
   initial begin
      sclk = 1'b1;
      din = 1'b0;
      irqFlag = 1'b0;
      #1;
      csN = 1'b1;
   end
   // Edge, not level, so a held request is taken once
   always @(negedge irqN) irqFlag = 1'b1;
   task automatic clearFlag();
      irqFlag = 1'b0;
   endtask : clearFlag
   // Clock stands high between frames
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wr, output logic [15:0] rd);
      logic [23:0] frame;
      frame = {cmd, wr};
      rd = 16'h0000;
      csN = 1'b0;
      #200;
      for (int i = 23; i >= 0; i--) begin
         #1;
         din = frame[i];
         #2;
         if (i < 16) rd = {rd[14:0], dout};
         sclk = 1'b0;
         #3;
         sclk = 1'b1;
      end
      #240;
      csN = 1'b1;
      din = ~din;
      #240;
   endtask : xfer
endmodule : mitc_host

/* verification/mitc_top_test.sv */
// Self-checking bench for the interrupt and temperature block
`timescale 1ns/1ps
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %s: expected %h, seen %h", w, e, g); end end
module mitc_top_test;
   import mitc_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic sclk, csN, din, dout, doutOeN, irqN, sensorRoute, modClk;
   logic [DATA_W-1:0] eventIn = '0;
   logic zeroCross = 1'b0;
   logic [CHANNELS-1:0] modBit = 2'b01;
   logic [WORD_W-1:0] ch1Word, ch2Word;
   logic [15:0] rd;
   logic [5:0] rstAddr [5] = '{ADDR_MODE, ADDR_ENABLES, ADDR_FLAGS, ADDR_TEMP, 6'h3F};
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   int n;
   always #20 mclk = ~mclk;
   mitc_top i_mitc_top (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .csN(csN), .din(din),
      .dout(dout), .doutOeN(doutOeN), .eventIn(eventIn), .zeroCross(zeroCross),
      .modBit(modBit), .irqN(irqN), .sensorRoute(sensorRoute), .modClk(modClk),
      .ch1Word(ch1Word), .ch2Word(ch2Word));
   mitc_host i_mitc_host (.sclk(sclk), .csN(csN), .din(din), .dout(dout), .irqN(irqN));
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #2;
   endtask : cyc
   task automatic rdReg(input logic [5:0] a, output logic [15:0] d);
      i_mitc_host.xfer({2'b00, a}, 16'h0000, d);
   endtask : rdReg
   task automatic wrReg(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] unused;
      i_mitc_host.xfer({2'b10, a}, d, unused);
   endtask : wrReg
   task automatic pulse(input logic [15:0] ev, input logic zc);
      cyc(1);
      eventIn = ev;
      zeroCross = zc;
      cyc(1);
      eventIn = '0;
      zeroCross = 1'b0;
   endtask : pulse
   initial begin
      cyc(12);
      sys_rst = 1'b0;
      cyc(6);
      wrReg(ADDR_FLAGS, 16'hFFFF);
      foreach (rstAddr[i]) begin
         rdReg(rstAddr[i], rd);
         `CHK("reset read", 16'h0000, rd)
      end
      pulse(16'h0000, 1'b1);
      cyc(3);
      `CHK("route idle", 1'b0, sensorRoute)
      pulse(16'h0008, 1'b0);
      cyc(3);
      `CHK("irq masked", 1'b1, irqN)
      rdReg(ADDR_FLAGS, rd);
      `CHK("flags", 16'h0008, rd)
      rdReg(ADDR_FLAGS, rd);
      `CHK("flags kept", 16'h0008, rd)
      rdReg(ADDR_STATUS_CLR, rd);
      `CHK("status clear", 16'h0008, rd)
      rdReg(ADDR_FLAGS, rd);
      `CHK("flags cleared", 16'h0000, rd)
      wrReg(ADDR_ENABLES, 16'h0028);
      rdReg(ADDR_ENABLES, rd);
      `CHK("enables", 16'h0028, rd)
      pulse(16'h0008, 1'b0);
      cyc(3);
      `CHK("irq", 1'b0, irqN)
      `CHK("host edge", 1'b1, i_mitc_host.irqFlag)
      i_mitc_host.clearFlag();
      fork
         rdReg(ADDR_STATUS_CLR, rd);
         begin
            n = 0;
            while (irqN !== 1'b1 && n < 40) begin
               cyc(1);
               n++;
            end
            `CHK("irq released", 1'b1, irqN)
            pulse(16'h0008, 1'b0);
         end
      join
      `CHK("read with event", 16'h0008, rd)
      `CHK("irq again", 1'b0, irqN)
      `CHK("host edge again", 1'b1, i_mitc_host.irqFlag)
      rdReg(ADDR_STATUS_CLR, rd);
      `CHK("pending kept", 16'h0008, rd)
      `CHK("irq idle", 1'b1, irqN)
      // Temperature: channel one stream all ones gives a known byte
      wrReg(ADDR_MODE, 16'h0020);
      rdReg(ADDR_MODE, rd);
      `CHK("mode", 16'h0020, rd)
      pulse(16'h0000, 1'b1);
      cyc(1);
      `CHK("route", 1'b1, sensorRoute)
      n = 0;
      while (sensorRoute === 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      `CHK("conversion time", 1'b1, n >= 88 && n <= 97)
      cyc(2);
      `CHK("temp irq", 1'b0, irqN)
      rdReg(ADDR_TEMP, rd);
      `CHK("temperature", 16'h0040, rd)
      rdReg(ADDR_MODE, rd);
      `CHK("mode done", 16'h0000, rd)
      rdReg(ADDR_STATUS_CLR, rd);
      `CHK("temp flag", TEMP_FLAG_MASK, rd)
      `CHK("ch1 high", 24'h400000, ch1Word)
      `CHK("ch2 low", 24'hC00000, ch2Word)
      // Serial frames end off the clock grid; realign before touching the streams
      cyc(1);
      modBit = 2'b10;
      cyc(300);
      `CHK("ch1 low", 24'hC00000, ch1Word)
      `CHK("ch2 high", 24'h400000, ch2Word)
      report_and_stop();
   end
endmodule : mitc_top_test
